/* verilog/cursor_shadow_pkg.sv */
// constants and types shared by the cursor shadow register bank
package cursor_shadow_pkg;

    // register byte offsets: request (holding) copies
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BASE = 8'h04;
    localparam logic [7:0] OFS_POS = 8'h08;
    localparam logic [7:0] OFS_TINT0 = 8'h0C;
    // register byte offsets: status (active) twins
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_CUR_BASE = 8'h24;
    localparam logic [7:0] OFS_CUR_POS = 8'h28;
    localparam logic [7:0] OFS_CUR_TINT0 = 8'h2C;
    localparam logic [7:0] OFS_STRIDE = 8'h04;

    // control / status field positions
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_SIZE_LSB = 4;
    localparam int STAT_ARMED_BIT = 8;

    // base address alignment (128 bytes) and split into upper/lower parts
    localparam int BASE_ALIGN_BITS = 7;
    localparam int BASE_SPLIT_BIT = 16;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [23:0] RST_TINT = 24'h0000_0000;

    // cursor image styles
    typedef enum logic [2:0] {
        STYLE_TWO_COL = 3'b000,
        STYLE_THREE_COL = 3'b001,
        STYLE_FOUR_COL = 3'b010,
        STYLE_RGB = 3'b011,
        STYLE_MASKED_RGB = 3'b100
    } style_t;

    // cursor square dimension
    typedef enum logic [1:0] {
        DIM_32 = 2'b00,
        DIM_48 = 2'b01,
        DIM_64 = 2'b10
    } dim_t;

    localparam logic [6:0] PIX_32 = 7'd32;
    localparam logic [6:0] PIX_48 = 7'd48;
    localparam logic [6:0] PIX_64 = 7'd64;

    // one full cursor configuration (holding or active)
    typedef struct packed {
        logic [31:0] image_start;
        logic [31:0] place;
        logic [3:0][23:0] tint;
        style_t style;
        dim_t dim;
        logic on;
    } cursor_cfg_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // dma fetch descriptor handed to the cursor dma engine
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [8:0] len;
    } fetch_t;

endpackage

/* verilog/cursor_line_addr.sv */
// cursor line length and dram byte address from the active settings
`timescale 1ns/1ps
`default_nettype none

module cursor_line_addr (
    // active configuration
    input wire logic [31:0] image_start,
    input wire cursor_shadow_pkg::dim_t dim,
    input wire cursor_shadow_pkg::style_t style,
    // line number inside the cursor image
    input wire logic [5:0] line,
    // result
    output logic [31:0] addr,
    output logic [8:0] len
);

    logic [15:0] image_start_upper;
    logic [8:0] image_start_lower;
    logic [6:0] width;
    logic [14:0] offset;

    // address is rebuilt from the two stored parts of the base
    assign image_start_upper = image_start[31:cursor_shadow_pkg::BASE_SPLIT_BIT];
    assign image_start_lower =
        image_start[cursor_shadow_pkg::BASE_SPLIT_BIT-1:cursor_shadow_pkg::BASE_ALIGN_BITS];

    // width in pixels; an illegal dim code falls back to the largest
    always_comb
    begin
        unique case (dim)
            cursor_shadow_pkg::DIM_32: width = cursor_shadow_pkg::PIX_32;
            cursor_shadow_pkg::DIM_48: width = cursor_shadow_pkg::PIX_48;
            default: width = cursor_shadow_pkg::PIX_64;
        endcase
    end

    // RULE17 - 2bpp line bytes
    // RULE18 - 32bpp line bytes
    always_comb
    begin
        if ((style == cursor_shadow_pkg::STYLE_RGB) ||
            (style == cursor_shadow_pkg::STYLE_MASKED_RGB))
            len = {width, 2'b00};
        else
            len = {4'b0000, width[6:2]};
    end

    // RULE16 - line address composition
    assign offset = 15'(line * len);
    assign addr = {image_start_upper, image_start_lower, 7'h00} + {17'h0_0000, offset};

endmodule

`default_nettype wire

/* verilog/cursor_shadow_regs.sv */
// double-buffered hardware cursor configuration bank with apb access
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1 - request writes go to holding copies; status twins return active values
// RULE2 - seven pairs: control, image start, place, tint 0 to 3
// RULE3 - any place write sets update_armed
// RULE4 - at vblank start with armed, copy all holding to active, clear armed
// RULE5 - software keeps control, start and tints unchanged while armed
// RULE6 - display engine stopped: writes reach active values at once; here they reach them one cycle after the holding write
// RULE7 - style comes from control style field, active style shown in status
// RULE8 - style codes 000/001/010 two bits per pixel, 011/100 32 bits
// RULE9 - tint registers give red, green, blue for the colour styles
// RULE10 - dim field picks 32, 48 or 64 square; active dim in status
// RULE11 - on bit starts fetch and image; clearing acts only once applied
// RULE12 - status shows active style, dim and on state separately
// RULE13 - update_armed reads one while a change is pending, else zero
// RULE14 - writing one to update_armed cancels, unless transfer hits same cycle
// RULE15 - image start is 128 byte aligned, selects one stored image
// RULE16 - per-line dram address from active start parts, line, dim, style
// RULE17 - 2bpp lines take 8, 12 or 16 bytes
// RULE18 - 32bpp lines take 128, 192 or 256 bytes
// RULE19 - place holds signed x and y of the top-left corner
// RULE20 - cursor pixels outside the active screen are clipped
// RULE21 - software keeps one pixel on screen with negative coordinates
// RULE22 - place rewrite while armed applies only if written before vblank
module cursor_shadow_regs (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // display engine timing, same clock
    input wire logic controller_running_flag,
    input wire logic vblank,
    input wire logic [11:0] h_count,
    input wire logic [11:0] v_count,
    input wire logic [11:0] h_active_last,
    input wire logic [11:0] v_active_last,
    // cursor dma engine
    input wire logic line_req,
    input wire logic [5:0] line_num,
    output logic fetch_enable,
    output logic fetch_valid,
    output logic [31:0] fetch_addr,
    output logic [8:0] fetch_len,
    // cursor merge stage
    output logic pixel_hit,
    output cursor_shadow_pkg::style_t cursor_style_active,
    output logic [1:0] tint_sel_hint,
    output logic [23:0] cursor_tint0_active,
    output logic [23:0] cursor_tint1_active,
    output logic [23:0] cursor_tint2_active,
    output logic [23:0] cursor_tint3_active
);

    // whole module state
    typedef struct packed {
        cursor_shadow_pkg::cursor_cfg_t hold;
        cursor_shadow_pkg::cursor_cfg_t act;
        logic update_armed;
        logic vblank_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        cursor_shadow_pkg::fetch_t fetch;
        logic hit;
    } state_t;

    state_t state_q;
    state_t state_d;

    cursor_shadow_pkg::apb_req_t req;
    logic [31:0] line_addr;
    logic [8:0] line_len;

    // RULE2 - seven register pairs
    // index of a decoded register: 0..6 request, 8..14 status, 15 none
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        logic [3:0] idx;
        idx = 4'hF;
        if (a == cursor_shadow_pkg::OFS_CTRL)
            idx = 4'h0;
        else if (a == cursor_shadow_pkg::OFS_BASE)
            idx = 4'h1;
        else if (a == cursor_shadow_pkg::OFS_POS)
            idx = 4'h2;
        else if (a == cursor_shadow_pkg::OFS_STATUS)
            idx = 4'h8;
        else if (a == cursor_shadow_pkg::OFS_CUR_BASE)
            idx = 4'h9;
        else if (a == cursor_shadow_pkg::OFS_CUR_POS)
            idx = 4'hA;
        for (int i = 0; i < 4; i++)
        begin
            if (a == 8'(cursor_shadow_pkg::OFS_TINT0 + 8'(i) * cursor_shadow_pkg::OFS_STRIDE))
                idx = 4'(3 + i);
            if (a == 8'(cursor_shadow_pkg::OFS_CUR_TINT0 +
                         8'(i) * cursor_shadow_pkg::OFS_STRIDE))
                idx = 4'(11 + i);
        end
        return idx;
    endfunction

    // cursor square size in pixels, as signed for the clip compare
    function automatic logic signed [16:0] dim_pixels(input cursor_shadow_pkg::dim_t d);
        logic signed [16:0] px;
        px = 17'sd64;
        if (d == cursor_shadow_pkg::DIM_32)
            px = 17'sd32;
        else if (d == cursor_shadow_pkg::DIM_48)
            px = 17'sd48;
        return px;
    endfunction

    // readback of one configuration as the control word
    function automatic logic [31:0] ctrl_word(input cursor_shadow_pkg::cursor_cfg_t c);
        logic [31:0] w;
        w = cursor_shadow_pkg::RST_WORD;
        w[cursor_shadow_pkg::CTRL_ON_BIT] = c.on;
        w[cursor_shadow_pkg::CTRL_MODE_LSB +: 3] = c.style;
        w[cursor_shadow_pkg::CTRL_SIZE_LSB +: 2] = c.dim;
        return w;
    endfunction

    assign req.psel = psel;
    assign req.penable = penable;
    assign req.pwrite = pwrite;
    assign req.paddr = paddr;
    assign req.pwdata = pwdata;

    // line address for the current dma request, from active values only
    cursor_line_addr u_line_addr (
        .image_start(state_q.act.image_start),
        .dim(state_q.act.dim),
        .style(state_q.act.style),
        .line(line_num),
        .addr(line_addr),
        .len(line_len)
    );

    // next-state logic for the whole bank
    always_comb
    begin
        logic [3:0] idx;
        logic wr;
        logic vblank_rise;
        logic transfer;
        logic cancel;
        logic place_wr;
        logic signed [16:0] dx;
        logic signed [16:0] dy;
        logic signed [16:0] px;
        logic in_box;
        logic on_screen;

        state_d = state_q;
        transfer = 1'b0;
        dx = 17'sd0;
        dy = 17'sd0;
        px = 17'sd0;
        in_box = 1'b0;
        on_screen = 1'b0;
        idx = reg_index(req.paddr);
        wr = req.psel & req.penable & req.pwrite & state_q.pready;
        vblank_rise = vblank & ~state_q.vblank_prev;
        place_wr = wr && (idx == 4'h2);
        cancel = wr && (idx == 4'h8) && req.pwdata[cursor_shadow_pkg::STAT_ARMED_BIT];

        // apb: one wait-free access phase; answer is prepared in setup
        state_d.pready = req.psel & ~req.penable;
        state_d.pslverr = 1'b0;
        if (req.psel & ~req.penable)
        begin
            state_d.prdata = cursor_shadow_pkg::RST_WORD;
            state_d.pslverr = (idx == 4'hF);
            unique case (idx)
                4'h0: state_d.prdata = ctrl_word(state_q.hold);
                4'h1: state_d.prdata = state_q.hold.image_start;
                4'h2: state_d.prdata = state_q.hold.place;
                // RULE12 - status fields
                // RULE13 - armed readback
                4'h8:
                begin
                    state_d.prdata = ctrl_word(state_q.act);
                    state_d.prdata[cursor_shadow_pkg::STAT_ARMED_BIT] = state_q.update_armed;
                end
                4'h9: state_d.prdata = state_q.act.image_start;
                4'hA: state_d.prdata = state_q.act.place;
                4'h3, 4'h4, 4'h5, 4'h6:
                    state_d.prdata = {8'h00, state_q.hold.tint[idx[1:0] - 2'd3]};
                4'hB, 4'hC, 4'hD, 4'hE:
                    state_d.prdata = {8'h00, state_q.act.tint[idx[1:0] - 2'd3]};
                default: state_d.prdata = cursor_shadow_pkg::RST_WORD;
            endcase
        end

        // RULE4 - vblank transfer
        // RULE6 - stopped engine applies
        // stopped engine copies every cycle, so writes show one cycle later
        transfer = (vblank_rise & state_q.update_armed) | ~controller_running_flag;
        if (transfer)
            state_d.act = state_q.hold;

        // RULE1 - writes to holding
        // RULE5 - software keeps steady
        // control, start and tints are not guarded while armed: software owns that
        if (wr)
        begin
            unique case (idx)
                // RULE7 - style field
                // RULE10 - dim field
                // RULE11 - on bit
                4'h0:
                begin
                    state_d.hold.on = req.pwdata[cursor_shadow_pkg::CTRL_ON_BIT];
                    state_d.hold.style =
                        cursor_shadow_pkg::style_t'(req.pwdata[cursor_shadow_pkg::CTRL_MODE_LSB +: 3]);
                    state_d.hold.dim =
                        cursor_shadow_pkg::dim_t'(req.pwdata[cursor_shadow_pkg::CTRL_SIZE_LSB +: 2]);
                end
                // RULE15 - aligned image start
                4'h1: state_d.hold.image_start =
                    {req.pwdata[31:cursor_shadow_pkg::BASE_ALIGN_BITS], 7'h00};
                // RULE19 - signed place
                // RULE22 - place rewrite
                4'h2: state_d.hold.place = req.pwdata;
                // RULE9 - tint values
                4'h3, 4'h4, 4'h5, 4'h6:
                    state_d.hold.tint[idx[1:0] - 2'd3] = req.pwdata[23:0];
                default: state_d.hold = state_q.hold;
            endcase
        end

        // RULE3 - place write arms
        // RULE14 - cancel by one
        // a place write in the transfer cycle re-arms: set wins over clear
        state_d.update_armed = (state_q.update_armed & ~transfer & ~cancel) | place_wr;
        state_d.vblank_prev = vblank;

        // RULE11 - fetch from active on
        state_d.fetch.valid = line_req & state_q.act.on;
        state_d.fetch.addr = line_addr;
        state_d.fetch.len = line_len;

        // RULE20 - screen clipping
        dx = $signed({5'b00000, h_count}) - $signed({state_q.act.place[15], state_q.act.place[15:0]});
        dy = $signed({5'b00000, v_count}) - $signed({state_q.act.place[31], state_q.act.place[31:16]});
        px = dim_pixels(state_q.act.dim);
        in_box = (dx >= 17'sd0) && (dx < px) && (dy >= 17'sd0) && (dy < px);
        on_screen = (h_count <= h_active_last) && (v_count <= v_active_last);
        state_d.hit = state_q.act.on & in_box & on_screen;
    end

    // single state register, cleared under reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    // outputs straight from the state flops
    assign prdata = state_q.prdata;
    assign pready = state_q.pready;
    assign pslverr = state_q.pslverr;
    assign fetch_enable = state_q.act.on;
    assign fetch_valid = state_q.fetch.valid;
    assign fetch_addr = state_q.fetch.addr;
    assign fetch_len = state_q.fetch.len;
    assign pixel_hit = state_q.hit;
    // RULE8 - active style code
    assign cursor_style_active = state_q.act.style;
    assign tint_sel_hint = state_q.act.dim;
    assign cursor_tint0_active = state_q.act.tint[0];
    assign cursor_tint1_active = state_q.act.tint[1];
    assign cursor_tint2_active = state_q.act.tint[2];
    assign cursor_tint3_active = state_q.act.tint[3];

endmodule

`default_nettype wire

/* dv/cursor_shadow_chk.sv */
// port assertions for the cursor shadow register bank
`timescale 1ns/1ps
`default_nettype none
module cursor_shadow_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // display timing
    input wire logic controller_running_flag,
    input wire logic vblank,
    input wire logic [11:0] h_count,
    input wire logic [11:0] v_count,
    input wire logic [11:0] h_active_last,
    input wire logic [11:0] v_active_last,
    // dma and merge side
    input wire logic line_req,
    input wire logic fetch_enable,
    input wire logic fetch_valid,
    input wire logic [8:0] fetch_len,
    input wire logic pixel_hit,
    input wire cursor_shadow_pkg::style_t cursor_style_active,
    input wire logic [1:0] tint_sel_hint
);
    logic vb_q;
    logic may_move;
    logic in_scr;
    logic [8:0] len_x;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // vblank one cycle late, so that its rise can be seen
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            vb_q <= 1'b0;
        else
            vb_q <= vblank;
    // when active values may move, and whether a pixel lies on screen
    assign may_move = !controller_running_flag || (vblank && !vb_q);
    assign in_scr = fetch_enable && h_count <= h_active_last && v_count <= v_active_last;
    // line length of the active setting; 32 bpp lines are sixteen times longer
    always_comb
    begin
        len_x = (tint_sel_hint == 2'h0) ? 9'h008 : (tint_sel_hint == 2'h1) ? 9'h00C : 9'h010;
        if (cursor_style_active > cursor_shadow_pkg::STYLE_FOUR_COL)
            len_x = len_x << 4;
    end
    // bus handshake
    access_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    unmapped_zero_a: assert property (pslverr && !pwrite |-> pready && !(|prdata))
        else $error("unmapped read not zero");
    // fetch answers
    fetch_on_a: assert property (line_req && fetch_enable |=> fetch_valid)
        else $error("line request not answered");
    fetch_off_a: assert property (line_req && !fetch_enable |=> !fetch_valid)
        else $error("fetch while cursor off");
    line_len_a: assert property (fetch_valid |-> fetch_len == len_x)
        else $error("wrong line length");
    // active style and dim move only at a transfer or with the engine stopped; hits lie on screen
    style_hold_a: assert property ($changed({cursor_style_active, tint_sel_hint})
        |-> $past(may_move))
        else $error("active style moved outside transfer");
    clip_a: assert property (pixel_hit |-> $past(in_scr))
        else $error("pixel shown off screen");
endmodule
bind cursor_shadow_regs cursor_shadow_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .controller_running_flag, .vblank, .h_count, .v_count,
    .h_active_last, .v_active_last, .line_req, .fetch_enable, .fetch_valid, .fetch_len,
    .pixel_hit, .cursor_style_active, .tint_sel_hint);
`default_nettype wire

/* dv/cursor_dma_model.sv */
// model of the dma engine that asks for cursor lines
`timescale 1ns/1ps
`default_nettype none
module cursor_dma_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic go,
    input wire logic slow,
    output logic busy,
    // line requests
    output logic line_req,
    output logic [5:0] line_num,
    // answers and what was seen
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic [8:0] fetch_len,
    output logic [6:0] n_got,
    output logic [31:0] got_addr,
    output logic [8:0] got_len
);
    initial
    begin
        busy = 1'b0;
        line_req = 1'b0;
        line_num = 6'h00;
    end
    // walk all 64 lines, back to back or with gaps
    always @(posedge pclk)
        if (go && presetn)
        begin
            busy <= 1'b1;
            for (int l = 0; l < 64; l++)
            begin
                line_req <= 1'b1;
                line_num <= 6'(l);
                @(posedge pclk);
                if (slow)
                begin
                    // a released line number is scrambled, never held
                    line_req <= 1'b0;
                    line_num <= ~line_num;
                    repeat (2) @(posedge pclk);
                end
            end
            line_req <= 1'b0;
            line_num <= ~line_num;
            repeat (2) @(posedge pclk);
            busy <= 1'b0;
        end
    // count answers and keep the last one
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            n_got <= 7'h00;
        else if (go)
            n_got <= 7'h00;
        else if (fetch_valid)
        begin
            n_got <= n_got + 7'h01;
            got_addr <= fetch_addr;
            got_len <= fetch_len;
        end
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the cursor shadow register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {logic [7:0] a, ra; logic [31:0] d, x; logic e;} row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic controller_running_flag = 1'b0, vblank = 1'b0, go = 1'b0, slow = 1'b0;
    logic pready, pslverr, fetch_enable, fetch_valid, pixel_hit, line_req, busy, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, fetch_addr, got_addr, rd, cw, base, prev;
    logic [11:0] h_count = 12'h000, v_count = 12'h000;
    logic [11:0] h_active_last = 12'h27F, v_active_last = 12'h1DF;
    logic [8:0] fetch_len, got_len, len;
    logic [6:0] n_got;
    logic [5:0] line_num;
    logic [1:0] tint_sel_hint;
    logic [23:0] tints [4];
    cursor_shadow_pkg::style_t cursor_style_active;
    int err_total = 0, n_tests = 0, cyc = 0;
    // request, twin, data written, twin value expected, error expected
    row_t rows [9] = '{
        '{8'h00, 8'h20, 32'h0000_0025, 32'h0000_0025, 1'b0},
        '{8'h04, 8'h24, 32'h1234_56FF, 32'h1234_5680, 1'b0},
        '{8'h08, 8'h28, 32'hFFF0_0010, 32'hFFF0_0010, 1'b0},
        '{8'h0C, 8'h2C, 32'h0011_2233, 32'h0011_2233, 1'b0},
        '{8'h10, 8'h30, 32'h0044_5566, 32'h0044_5566, 1'b0},
        '{8'h14, 8'h34, 32'h0077_8899, 32'h0077_8899, 1'b0},
        '{8'h18, 8'h38, 32'h00AA_BBCC, 32'h00AA_BBCC, 1'b0},
        '{8'h24, 8'h24, 32'h0000_0080, 32'h1234_5680, 1'b0},
        '{8'h40, 8'h40, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}
    };
    cursor_shadow_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .controller_running_flag, .vblank, .h_count, .v_count,
        .h_active_last, .v_active_last, .line_req, .line_num, .fetch_enable, .fetch_valid,
        .fetch_addr, .fetch_len, .pixel_hit, .cursor_style_active, .tint_sel_hint,
        .cursor_tint0_active(tints[0]), .cursor_tint1_active(tints[1]),
        .cursor_tint2_active(tints[2]), .cursor_tint3_active(tints[3]));
    cursor_dma_model i_dma (.pclk, .presetn, .go, .slow, .busy, .line_req, .line_num,
        .fetch_valid, .fetch_addr, .fetch_len, .n_got, .got_addr, .got_len);
    always #20 pclk = ~pclk;
    // hang guard: the whole run needs about eleven hundred cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic vb();
        vblank <= 1'b1;
        repeat (3) @(posedge pclk);
        vblank <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic dma(input logic s, input logic [6:0] n, input logic [31:0] a, input logic [8:0] l);
        slow <= s;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (2) @(posedge pclk);
        while (busy)
            @(posedge pclk);
        chk(n_got, n);
        if (n != 7'h00)
        begin
            chk(got_addr, a);
            chk(got_len, l);
        end
    endtask
    task automatic hit(input logic [11:0] h, input logic [11:0] v, input logic e);
        h_count <= h;
        v_count <= v;
        repeat (2) @(posedge pclk);
        chk(pixel_hit, e);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(fetch_enable, 1'b0);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // engine stopped: every request shows in its twin one cycle after the write
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].ra, 32'h0000_0000);
            chk(rd, rows[i].x);
            chk(er, rows[i].e);
        end
        // active tint outputs follow the tint rows written above
        for (int t = 0; t < 4; t++)
            chk(32'(tints[t]), rows[3 + t].x);
        $display("register rows done");
        controller_running_flag <= 1'b1;
        prev = 32'h0000_0025;
        for (int s = 0; s < 5; s++)
        begin
            cw = 32'((s % 3) * 16 + s * 2 + 1);
            base = 32'(s + 1) << 16;
            len = (s % 3 == 0) ? 9'h008 : (s % 3 == 1) ? 9'h00C : 9'h010;
            if (s > 2)
                len = len << 4;
            apb(1'b1, 8'h00, cw);
            apb(1'b1, 8'h04, base);
            apb(1'b1, 8'h08, 32'h0010_0020);
            apb(1'b0, 8'h20, 32'h0000_0000);
            chk(rd, prev | 32'h0000_0100);
            vb();
            apb(1'b0, 8'h20, 32'h0000_0000);
            chk(rd, cw);
            chk(cursor_style_active, 32'(s));
            chk(tint_sel_hint, 32'(s % 3));
            dma(s[0], 7'h40, base + 32'(len) * 32'h0000_003F, len);
            prev = cw;
        end
        // cancel, then a newer place before blanking
        apb(1'b1, 8'h08, 32'h0030_0040);
        apb(1'b1, 8'h20, 32'h0000_0100);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(rd, prev);
        vb();
        apb(1'b0, 8'h28, 32'h0000_0000);
        chk(rd, 32'h0010_0020);
        apb(1'b1, 8'h08, 32'h0050_0060);
        apb(1'b1, 8'h08, 32'h0070_0080);
        vb();
        apb(1'b0, 8'h28, 32'h0000_0000);
        chk(rd, 32'h0070_0080);
        // switching off lands only at the next transfer
        apb(1'b1, 8'h00, prev & 32'hFFFF_FFFE);
        apb(1'b1, 8'h08, 32'h0070_0080);
        dma(1'b1, 7'h40, base + 32'(len) * 32'h0000_003F, len);
        vb();
        chk(fetch_enable, 1'b0);
        dma(1'b0, 7'h00, 32'h0000_0000, 9'h000);
        $display("transfer tests done");
        // clipping at the right edge and below a negative top
        controller_running_flag <= 1'b0;
        apb(1'b1, 8'h00, 32'h0000_0001);
        apb(1'b1, 8'h08, 32'hFFFC_0276);
        hit(12'h276, 12'h000, 1'b1);
        hit(12'h275, 12'h000, 1'b0);
        hit(12'h27F, 12'h01B, 1'b1);
        hit(12'h280, 12'h01B, 1'b0);
        hit(12'h276, 12'h01C, 1'b0);
        // a line below the last visible one is clipped too
        v_active_last <= 12'h01A;
        hit(12'h27F, 12'h01B, 1'b0);
        $display("clip tests done");
        // mid-run reset clears the active copy and the armed flag
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(fetch_enable, 1'b0);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("reset test done");
        final_report();
    end
endmodule
`default_nettype wire
